//--- lts_defines.svh
/*
  Constants for the loop transceiver synchronous port: burst framing,
  timing counts at the core clock rate, register offsets, fields and
  reset values. Assumes a core clock of 125 MHz.
*/
`ifndef LTS_DEFINES_SVH
`define LTS_DEFINES_SVH

`define LTS_CLK_HZ 125000000
`define LTS_FRAME_US 125
`define LTS_BAUD_HZ 256000
`define LTS_DCLK_HZ 128000
`define LTS_BAUD_CYC (`LTS_CLK_HZ / `LTS_BAUD_HZ)
`define LTS_DCLK_HALF_CYC (`LTS_CLK_HZ / (2 * `LTS_DCLK_HZ))
`define LTS_GAP_BAUDS 4
`define LTS_GAP_CYC (`LTS_GAP_BAUDS * `LTS_BAUD_CYC)
`define LTS_BURST_BITS 10
`define LTS_BYTE_BITS 8
`define LTS_WIN_PERIODS 8

`define LTS_CTRL_OFS 8'h00
`define LTS_STAT_OFS 8'h04
`define LTS_CTRL_TXEN_BIT 0
`define LTS_CTRL_RST 32'h0000_0001
`define LTS_STAT_BYTE_LSB 0
`define LTS_STAT_SIG_LSB 8
`define LTS_STAT_BUSY_BIT 10
`define LTS_STAT_PD_BIT 11
`define LTS_STAT_LB_BIT 12
`define LTS_STAT_CNT_LSB 16

`define LTS_RESP_OKAY 2'b00
`define LTS_RESP_SLVERR 2'b10

`endif

//--- lts_pkg.sv
/*
  Types for the loop transceiver synchronous port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lts_pkg;

  typedef enum logic [1:0]
  {
    LTS_TX_IDLE = 2'b00,
    LTS_TX_GAP = 2'b01,
    LTS_TX_SEND = 2'b11
  } lts_tx_state_t;

  typedef enum logic [1:0]
  {
    LTS_RX_ARM = 2'b00,
    LTS_RX_RUN = 2'b01,
    LTS_RX_WAIT = 2'b11
  } lts_rx_state_t;

endpackage

//--- lts_burst_rx.sv
/*
  Burst demodulator back end: samples a 10-bit burst at mid-baud once
  carrier appears and pulses done with the word, MSB first.
  Assumes carrier and data are already synchronised to core_clk.
*/
`timescale 1ns/1ps
`include "lts_defines.svh"

module lts_burst_rx
  import lts_pkg::*;
#(
  parameter int BAUD_CYC = `LTS_BAUD_CYC,
  parameter int BITS = `LTS_BURST_BITS
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic blank,
  input wire logic carrier,
  input wire logic line_bit,
  output logic done,
  output logic [BITS-1:0] word
);

  localparam int CW = $clog2(BAUD_CYC + 1);

  lts_rx_state_t st_q;
  logic [CW-1:0] cnt_q;
  logic [3:0] nbit_q;
  wire tick = (cnt_q == '0);
  wire last_bit = (nbit_q == 4'(BITS - 1));

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      st_q <= LTS_RX_ARM;
      cnt_q <= '0;
      nbit_q <= 4'h0;
      done <= 1'b0;
      word <= '0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      case (st_q)
        LTS_RX_ARM:
        begin
          // own transmission is blanked outside master loopback so it does not look like a return burst
          if (carrier && !blank)
          begin
            st_q <= LTS_RX_RUN;
            cnt_q <= CW'(BAUD_CYC / 2);
            nbit_q <= 4'h0;
          end
        end
        LTS_RX_RUN:
        begin
          if (tick)
          begin
            word <= {word[BITS-2:0], line_bit};
            cnt_q <= CW'(BAUD_CYC - 1);
            nbit_q <= nbit_q + 4'h1;
            if (last_bit)
            begin
              done <= 1'b1;
              st_q <= LTS_RX_WAIT;
            end
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        LTS_RX_WAIT:
        begin
          if (!carrier)
            st_q <= LTS_RX_ARM;
        end
        default: st_q <= LTS_RX_ARM;
      endcase
    end
  end

endmodule

//--- lts_transceiver_port.sv
/*
  Digital framing and synchronous data port of a ping-pong burst loop
  transceiver, master or slave by parameter, with an AXI4-Lite register
  slave. Assumes the analog front end delivers carrier and sliced data on
  line_input and turns line_outputs into the line signal.
*/
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
// Function
// - every 125 us frame carries one 10-bit burst each way: 8 data, 2 signalling
// - bursts go out at 256 kilobaud, half duplex, ping-pong
// - master starts its burst on the rising edge of frame sync
// - slave replies four baud periods after the master's last bit
// - slave window enable rises at end of demodulation, stays eight clock periods
// - master shifts out received byte on first eight rising clock edges in window
// - master samples outgoing byte on first eight falling clock edges in window
// - master moves signalling bits in and out on frame sync rise
// - slave makes its own clock and windows, shifts out on rising edges
// - slave captures outgoing data on falling clock edges in its window
// - slave moves signalling bits on the rise of its transmit window
// - master has pin power-down and loopback for testing
// - master insert enable carries signalling a in the data byte LSB
// - tristate enable gates power-down, loopback and signalling outputs
// - eight data bits and one bit per signalling channel buffered per frame
// - master loopback isolates line input, idles outputs, loops modulator back
// - slave loopback replaces port input byte with received byte
// - power-down stops everything but the receiver; the code only stops the transmitter, port and slave clock keep running
`timescale 1ns/1ps
`include "lts_defines.svh"

module lts_transceiver_port
  import lts_pkg::*;
#(
  parameter bit IS_MASTER = 1'b1,
  parameter int BAUD_CYC = `LTS_BAUD_CYC,
  parameter int DCLK_HALF_CYC = `LTS_DCLK_HALF_CYC,
  parameter int GAP_CYC = `LTS_GAP_CYC,
  parameter int AW = 8
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic master_frame_sync,
  input wire logic port_data_clock,
  input wire logic transmit_window_enable,
  input wire logic receive_window_enable,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic signalling_in_a,
  input wire logic signalling_in_b,
  output logic signalling_out_a,
  output logic signalling_out_b,
  output logic signalling_out_oe,
  input wire logic power_down_n,
  input wire logic loopback_n,
  input wire logic lsb_channel_insert_enable,
  input wire logic control_tristate_enable,
  input wire logic [1:0] line_input,
  output logic [1:0] line_outputs,
  output logic gen_port_data_clock,
  output logic gen_transmit_window_enable,
  output logic gen_receive_window_enable,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NB = `LTS_BURST_BITS;
  localparam logic [3:0] BYTE_N = 4'(`LTS_BYTE_BITS);
  localparam logic [3:0] WIN_N = 4'(`LTS_WIN_PERIODS);
  localparam int BW = $clog2(BAUD_CYC + 1);
  localparam int GW = $clog2(GAP_CYC + 1);
  localparam int DW = $clog2(DCLK_HALF_CYC + 1);
  // positions in the synchroniser vector
  localparam int FS = 12, PC = 11, TW = 10, RW = 9, SIN = 8, SA = 7, SB = 6;
  localparam int PDN = 5, LBN = 4, LIE = 3, TSE = 2, LC = 1, LD = 0;

  // every pin input passes two flops before use
  logic [12:0] sy1_q, sy2_q;
  wire [12:0] ext_in = {master_frame_sync, port_data_clock, transmit_window_enable,
    receive_window_enable, serial_in, signalling_in_a, signalling_in_b,
    power_down_n, loopback_n, lsb_channel_insert_enable, control_tristate_enable,
    line_input};
  logic fs_prev_q, pc_prev_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sy1_q <= 13'h0000;
      sy2_q <= 13'h0000;
      fs_prev_q <= 1'b0;
      pc_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sy1_q <= ext_in;
      sy2_q <= sy1_q;
      fs_prev_q <= sy2_q[FS];
      pc_prev_q <= sy2_q[PC];
    end
  end

  wire fs_rise = sy2_q[FS] & ~fs_prev_q;
  wire pc_rise = sy2_q[PC] & ~pc_prev_q;
  wire pc_fall = ~sy2_q[PC] & pc_prev_q;

  // power-down and loopback pins only take effect while the tristate enable is high
  logic pd_n_q, lb_n_q;
  logic [31:0] ctrl_q;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pd_n_q <= 1'b1;
      lb_n_q <= 1'b1;
    end
    else if (clk_en && sy2_q[TSE])
    begin
      pd_n_q <= sy2_q[PDN];
      lb_n_q <= sy2_q[LBN];
    end
  end

  wire lb_on = ~lb_n_q;
  wire m_lb = IS_MASTER && lb_on;
  wire s_lb = !IS_MASTER && lb_on;
  wire tx_allow = ctrl_q[`LTS_CTRL_TXEN_BIT] & pd_n_q;
  wire ins_on = IS_MASTER && sy2_q[LIE];

  // transmitter
  lts_tx_state_t tx_st_q;
  logic [NB-1:0] tx_sr_q;
  logic [BW-1:0] bcnt_q;
  logic [3:0] tx_nb_q;
  logic [GW-1:0] gcnt_q;
  logic [7:0] hold_q, out_byte_q;
  logic [1:0] sig_tx_q, sig_rx_q;
  wire sending = (tx_st_q == LTS_TX_SEND);

  // master burst: held port byte, LSB optionally carrying signalling a
  wire [7:0] m_byte = ins_on ? {hold_q[7:1], sy2_q[SA]} : hold_q;
  wire [NB-1:0] m_word = {m_byte, sy2_q[SA], sy2_q[SB]};
  wire [NB-1:0] s_word = {hold_q, sig_tx_q};

  // receiver, with the modulator looped straight into it in master loopback
  wire rx_carrier = m_lb ? sending : sy2_q[LC];
  wire rx_bit = m_lb ? tx_sr_q[NB-1] : sy2_q[LD];
  wire rx_blank = sending && !m_lb;
  wire rx_done;
  wire [NB-1:0] rx_word;

  lts_burst_rx #(
    .BAUD_CYC(BAUD_CYC),
    .BITS(NB)
  ) u_rx (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .blank(rx_blank),
    .carrier(rx_carrier),
    .line_bit(rx_bit),
    .done(rx_done),
    .word(rx_word)
  );

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      tx_st_q <= LTS_TX_IDLE;
      tx_sr_q <= '0;
      bcnt_q <= '0;
      tx_nb_q <= 4'h0;
      gcnt_q <= '0;
    end
    else if (clk_en)
    begin
      case (tx_st_q)
        LTS_TX_IDLE:
        begin
          if (IS_MASTER && fs_rise && tx_allow)
          begin
            tx_st_q <= LTS_TX_SEND;
            tx_sr_q <= m_word;
            bcnt_q <= BW'(BAUD_CYC - 1);
            tx_nb_q <= 4'h0;
          end
          else if (!IS_MASTER && rx_done && tx_allow)
          begin
            tx_st_q <= LTS_TX_GAP;
            gcnt_q <= GW'(GAP_CYC - 1);
          end
        end
        LTS_TX_GAP:
        begin
          if (gcnt_q == '0)
          begin
            tx_st_q <= LTS_TX_SEND;
            tx_sr_q <= s_word;
            bcnt_q <= BW'(BAUD_CYC - 1);
            tx_nb_q <= 4'h0;
          end
          else
          begin
            gcnt_q <= gcnt_q - 1'b1;
          end
        end
        LTS_TX_SEND:
        begin
          if (bcnt_q == '0)
          begin
            tx_sr_q <= {tx_sr_q[NB-2:0], 1'b0};
            bcnt_q <= BW'(BAUD_CYC - 1);
            tx_nb_q <= tx_nb_q + 4'h1;
            if (tx_nb_q == 4'(NB - 1))
              tx_st_q <= LTS_TX_IDLE;
          end
          else
          begin
            bcnt_q <= bcnt_q - 1'b1;
          end
        end
        default: tx_st_q <= LTS_TX_IDLE;
      endcase
    end
  end

  // line drive: differential data while sending, reference level otherwise
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      line_outputs <= 2'b00;
    else if (clk_en)
      line_outputs <= (sending && !m_lb) ? {~tx_sr_q[NB-1], tx_sr_q[NB-1]} : 2'b00;
  end

  // slave port clock and windows, restarted by each received burst
  logic [DW-1:0] dcnt_q;
  logic [3:0] pcnt_q;
  wire dtog = (dcnt_q == '0);
  wire g_rise = dtog && !gen_port_data_clock;
  wire g_fall = dtog && gen_port_data_clock;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      dcnt_q <= '0;
      pcnt_q <= 4'h0;
      gen_port_data_clock <= 1'b0;
      gen_transmit_window_enable <= 1'b0;
      gen_receive_window_enable <= 1'b0;
    end
    else if (clk_en && !IS_MASTER)
    begin
      if (rx_done)
      begin
        dcnt_q <= DW'(DCLK_HALF_CYC - 1);
        gen_port_data_clock <= 1'b0;
        pcnt_q <= 4'h0;
        gen_transmit_window_enable <= 1'b1;
        gen_receive_window_enable <= 1'b1;
      end
      else
      begin
        dcnt_q <= dtog ? DW'(DCLK_HALF_CYC - 1) : dcnt_q - 1'b1;
        if (dtog)
          gen_port_data_clock <= ~gen_port_data_clock;
        if (g_fall && gen_transmit_window_enable)
        begin
          pcnt_q <= pcnt_q + 4'h1;
          if (pcnt_q == WIN_N - 4'h1)
          begin
            gen_transmit_window_enable <= 1'b0;
            gen_receive_window_enable <= 1'b0;
          end
        end
      end
    end
  end

  // port edges and windows: external for the master, generated for the slave
  wire rise_e = IS_MASTER ? pc_rise : g_rise;
  wire fall_e = IS_MASTER ? pc_fall : g_fall;
  wire win_tx = IS_MASTER ? sy2_q[TW] : gen_transmit_window_enable;
  wire win_rx = IS_MASTER ? sy2_q[RW] : gen_receive_window_enable;
  wire [7:0] in_next;

  logic [7:0] osr_q, isr_q;
  logic [3:0] ocnt_q, icnt_q;
  assign in_next = {isr_q[6:0], sy2_q[SIN]};

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      osr_q <= 8'h00;
      ocnt_q <= 4'h0;
      serial_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!win_tx)
      begin
        osr_q <= out_byte_q;
        ocnt_q <= 4'h0;
      end
      else if (rise_e && ocnt_q < BYTE_N)
      begin
        serial_out <= osr_q[7];
        osr_q <= {osr_q[6:0], 1'b0};
        ocnt_q <= ocnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      isr_q <= 8'h00;
      icnt_q <= 4'h0;
      hold_q <= 8'h00;
    end
    else if (clk_en)
    begin
      if (!win_rx)
        icnt_q <= 4'h0;
      else if (fall_e && icnt_q < BYTE_N)
      begin
        isr_q <= in_next;
        icnt_q <= icnt_q + 4'h1;
        if (icnt_q == BYTE_N - 4'h1)
          hold_q <= s_lb ? out_byte_q : in_next;
      end
    end
  end

  // received byte and signalling, moved to the outputs at the frame event
  logic [7:0] burst_cnt_q;
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      out_byte_q <= 8'h00;
      sig_rx_q <= 2'b00;
      sig_tx_q <= 2'b00;
      signalling_out_a <= 1'b0;
      signalling_out_b <= 1'b0;
      signalling_out_oe <= 1'b0;
      burst_cnt_q <= 8'h00;
    end
    else if (clk_en)
    begin
      signalling_out_oe <= sy2_q[TSE];
      if (rx_done)
      begin
        out_byte_q <= rx_word[NB-1:2];
        sig_rx_q <= rx_word[1:0];
        burst_cnt_q <= burst_cnt_q + 8'h01;
      end
      if (IS_MASTER && fs_rise)
      begin
        signalling_out_a <= ins_on ? out_byte_q[0] : sig_rx_q[1];
        signalling_out_b <= sig_rx_q[0];
      end
      if (!IS_MASTER && rx_done)
      begin
        signalling_out_a <= rx_word[1];
        signalling_out_b <= rx_word[0];
        sig_tx_q <= {sy2_q[SA], sy2_q[SB]};
      end
    end
  end

  // AXI4-Lite slave: one write and one read at a time, answers a read one cycle late and a write two cycles late
  logic aw_got_q, w_got_q;
  logic [AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  wire wr_ctrl = (awaddr_q == AW'(`LTS_CTRL_OFS));
  wire wr_stat = (awaddr_q == AW'(`LTS_STAT_OFS));
  wire wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
  wire rd_ctrl = (s_axi_araddr == AW'(`LTS_CTRL_OFS));
  wire rd_stat = (s_axi_araddr == AW'(`LTS_STAT_OFS));
  wire [31:0] stat_w = {8'h00, burst_cnt_q, 3'b000, lb_on, ~pd_n_q,
    tx_st_q != LTS_TX_IDLE, sig_rx_q, out_byte_q};
  wire [31:0] rd_mux = rd_ctrl ? ctrl_q : (rd_stat ? stat_w : 32'h0000_0000);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LTS_RESP_OKAY;
      ctrl_q <= `LTS_CTRL_RST;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ctrl || wr_stat) ? `LTS_RESP_OKAY : `LTS_RESP_SLVERR;
        if (wr_ctrl && wstrb0_q)
          ctrl_q <= {31'h0000_0000, wdata_q[`LTS_CTRL_TXEN_BIT]};
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LTS_RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= (rd_ctrl || rd_stat) ? `LTS_RESP_OKAY : `LTS_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

//--- lts_port_properties.sv
/*
  Checker for the loop transceiver port: line bursts, port and AXI timing.
  Assumes it is bound to lts_transceiver_port in the master role.
*/
`timescale 1ns/1ps
module lts_port_properties #(
  parameter int BAUD_CYC = 16
)
(
  input logic core_clk,
  input logic rst_b,
  input logic master_frame_sync,
  input logic transmit_window_enable,
  input logic control_tristate_enable,
  input logic serial_out,
  input logic signalling_out_a,
  input logic signalling_out_b,
  input logic signalling_out_oe,
  input logic [1:0] line_outputs,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_rready
);
  localparam int BURST_CYC = 10 * BAUD_CYC;
  logic [15:0] run_q;
  logic [3:0] since_q;
  logic sync_q;
  wire sending = line_outputs != 2'b00;
  wire sync_rise = master_frame_sync && !sync_q;
  // since_q saturates so a late line change never looks like a fresh sync
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      run_q <= 16'h0000;
      since_q <= 4'hF;
      sync_q <= 1'b0;
    end
    else
    begin
      run_q <= sending ? run_q + 16'h0001 : 16'h0000;
      sync_q <= master_frame_sync;
      if (sync_rise)
        since_q <= 4'h0;
      else if (since_q != 4'hF)
        since_q <= since_q + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  a_burst_length: assert property ($fell(sending) |-> run_q == BURST_CYC)
    else $error("line burst length wrong");
  a_line_shape: assert property (line_outputs != 2'b11)
    else $error("line outputs both high");
  a_burst_start: assert property ($rose(sending) |-> since_q inside {[1:8]})
    else $error("burst not tied to frame sync");
  a_sig_update: assert property ($changed({signalling_out_a, signalling_out_b}) |-> since_q < 4'h9)
    else $error("signalling out moved away from sync");
  a_serial_quiet: assert property ((!transmit_window_enable) [*6] |=> $stable(serial_out))
    else $error("serial out moved outside window");
  a_oe_follow: assert property ($stable(control_tristate_enable) [*6] |-> signalling_out_oe == control_tristate_enable)
    else $error("output enable not following pin");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read data");
endmodule

bind lts_transceiver_port lts_port_properties #(
  .BAUD_CYC(BAUD_CYC)
) u_props (.*);

//--- lts_far_end.sv
/*
  Far side of the master: port timing logic and the remote transceiver.
  Assumes line_outputs carry {~bit,bit} and line_input is {carrier,data}.
*/
`timescale 1ns/1ps
module lts_far_end #(
  parameter int BAUD = 16,
  parameter int GAP = 64
)
(
  input wire logic core_clk,
  input wire logic [1:0] line_outputs,
  input wire logic serial_out,
  output logic master_frame_sync,
  output logic port_data_clock,
  output logic transmit_window_enable,
  output logic receive_window_enable,
  output logic [1:0] line_input,
  output logic serial_in
);
  initial
  begin
    master_frame_sync = 1'b0;
    port_data_clock = 1'b0;
    transmit_window_enable = 1'b0;
    receive_window_enable = 1'b0;
    line_input = 2'b00;
    serial_in = 1'b0;
  end
  // one frame: sync, catch the master burst, reply, then a nine-period window
  task automatic run_frame(input logic [9:0] r, input logic [7:0] s, output logic snt,
    output logic [9:0] g, output logic [7:0] so, output logic ex);
    int n;
    begin
      g = 10'h000;
      n = 0;
      master_frame_sync <= 1'b1;
      while (line_outputs == 2'b00 && n < 40)
      begin
        @(posedge core_clk);
        n++;
      end
      snt = line_outputs != 2'b00;
      if (snt)
      begin
        repeat (BAUD / 2) @(posedge core_clk);
        for (int i = 9; i >= 0; i--)
        begin
          g[i] = line_outputs[0];
          repeat (BAUD) @(posedge core_clk);
        end
      end
      master_frame_sync <= 1'b0;
      repeat (GAP) @(posedge core_clk);
      for (int i = 9; i >= 0; i--)
      begin
        line_input <= {1'b1, r[i]};
        repeat (BAUD) @(posedge core_clk);
      end
      // carrier gone: the data line no longer holds the last bit
      line_input <= {1'b0, ~r[0]};
      repeat (40) @(posedge core_clk);
      transmit_window_enable <= 1'b1;
      receive_window_enable <= 1'b1;
      #20;
      for (int p = 0; p < 9; p++)
      begin
        port_data_clock = 1'b1;
        serial_in = (p < 8) ? s[7-p] : ~s[0];
        #62.5 port_data_clock = 1'b0;
        #62.5;
        if (p < 8)
          so[7-p] = serial_out;
        else
          ex = serial_out;
      end
      @(posedge core_clk);
      transmit_window_enable <= 1'b0;
      receive_window_enable <= 1'b0;
      serial_in <= ~serial_in;
      repeat (20) @(posedge core_clk);
    end
  endtask
endmodule

//--- tb.sv
/*
  Testbench for the master port: AXI register access and framed traffic.
  Assumes lts_far_end stands at the line and port side of the design.
*/
`timescale 1ns/1ps
`include "lts_defines.svh"
module tb;
  localparam int BAUD = 16;
  logic core_clk, rst_b = 1'b0, clk_en = 1'b1;
  logic control_tristate_enable = 1'b1, power_down_n = 1'b1, loopback_n = 1'b1;
  logic lsb_channel_insert_enable = 1'b0, signalling_in_a = 1'b0, signalling_in_b = 1'b0;
  logic master_frame_sync, port_data_clock, transmit_window_enable, receive_window_enable;
  logic serial_in, serial_out, signalling_out_a, signalling_out_b, signalling_out_oe;
  logic [1:0] line_input, line_outputs, s_axi_bresp, s_axi_rresp;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, hold, cnt = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hv = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [9:0] lr = 10'h000;
  int error_cnt = 0, n_tests = 0, cyc = 0;

  lts_transceiver_port #(
    .IS_MASTER(1'b1), .BAUD_CYC(BAUD), .DCLK_HALF_CYC(BAUD), .GAP_CYC(4 * BAUD), .AW(8)
  ) u_dut (.*, .gen_port_data_clock(), .gen_transmit_window_enable(),
    .gen_receive_window_enable());
  lts_far_end #(.BAUD(BAUD), .GAP(4 * BAUD)) u_far (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    begin
      n_tests++;
      if (g !== e)
      begin
        error_cnt++;
        $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
      end
    end
  endtask

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge core_clk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er, "bresp");
      @(posedge core_clk);
    end
  endtask

  task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string m);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge core_clk);
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed, m);
      chk(s_axi_rresp, er, m);
      @(posedge core_clk);
    end
  endtask

  // expected burst, port byte, signalling and status all follow from the stimulus
  task frame(input logic [9:0] r, input logic [7:0] s, input logic tx, input string nm);
    logic snt, ex;
    logic [9:0] g, w, re;
    logic [7:0] so;
    logic [1:0] sx;
    begin
      repeat (8) @(posedge core_clk);
      w = {hold, signalling_in_a, signalling_in_b};
      if (lsb_channel_insert_enable)
        w[2] = signalling_in_a;
      re = loopback_n ? r : w;
      sx = lsb_channel_insert_enable ? {lr[2], lr[0]} : lr[1:0];
      u_far.run_frame(r, s, snt, g, so, ex);
      chk(snt, tx, "burst sent");
      if (snt && hv)
        chk(g, w, "burst word");
      chk(so, re[9:2], "port byte");
      chk(ex, so[0], "extra edge");
      chk({signalling_out_a, signalling_out_b}, sx, "signalling out");
      cnt++;
      axr(`LTS_STAT_OFS, {8'h00, cnt, 3'b000, !loopback_n, !power_down_n, 1'b0, re[1:0],
        re[9:2]}, `LTS_RESP_OKAY, "status");
      hold = s;
      hv = 1'b1;
      lr = re;
      $display("test %s done", nm);
    end
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("[FAIL] %0t run too long", $time);
      summarize;
    end
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(signalling_out_oe, 1'b1, "oe high");
    axr(`LTS_CTRL_OFS, `LTS_CTRL_RST, `LTS_RESP_OKAY, "ctrl reset");
    axr(8'h08, 32'h0000_0000, `LTS_RESP_SLVERR, "unmapped read");
    axw(8'h0C, 32'hFFFF_FFFF, `LTS_RESP_SLVERR);
    axw(`LTS_STAT_OFS, 32'h0000_0000, `LTS_RESP_OKAY);
    $display("test registers done");
    signalling_in_a <= 1'b1;
    frame(10'h2A5, 8'hC3, 1'b1, "normal");
    lsb_channel_insert_enable <= 1'b1;
    frame(10'h15A, 8'h3C, 1'b1, "insert a");
    signalling_in_a <= 1'b0;
    signalling_in_b <= 1'b1;
    frame(10'h0F1, 8'h81, 1'b1, "insert b");
    lsb_channel_insert_enable <= 1'b0;
    axw(`LTS_CTRL_OFS, 32'h0000_0000, `LTS_RESP_OKAY);
    axr(`LTS_CTRL_OFS, 32'h0000_0000, `LTS_RESP_OKAY, "ctrl off");
    frame(10'h1C7, 8'h5A, 1'b0, "tx off");
    axw(`LTS_CTRL_OFS, `LTS_CTRL_RST, `LTS_RESP_OKAY);
    loopback_n <= 1'b0;
    frame(10'h33C, 8'hE7, 1'b0, "loopback");
    loopback_n <= 1'b1;
    power_down_n <= 1'b0;
    frame(10'h0AA, 8'h18, 1'b0, "power down");
    power_down_n <= 1'b1;
    control_tristate_enable <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(signalling_out_oe, 1'b0, "oe low");
    summarize;
  end
endmodule
